/* design/fcps_cfg.svh */
// constants for the flash command and poll host controller
`ifndef FCPS_CFG_SVH
`define FCPS_CFG_SVH
`define FCPS_ADDR_W 19
`define FCPS_DATA_W 16
`define FCPS_UL1_WORD 19'h00555
`define FCPS_UL2_WORD 19'h002AA
`define FCPS_UL1_BYTE 19'h00AAA
`define FCPS_UL2_BYTE 19'h00555
`define FCPS_D_AA 8'hAA
`define FCPS_D_55 8'h55
`define FCPS_D_A0 8'hA0
`define FCPS_D_20 8'h20
`define FCPS_D_90 8'h90
`define FCPS_D_00 8'h00
`define FCPS_D_80 8'h80
`define FCPS_D_10 8'h10
`define FCPS_D_30 8'h30
`define FCPS_D_B0 8'hB0
`define FCPS_D_F0 8'hF0
`define FCPS_BANK_LSB 16
`define FCPS_POLL_BIT 7
`define FCPS_TOGGLE_BIT 6
`define FCPS_TIMEOUT_BIT 5
`define FCPS_ID_MAKER_OFS 19'h00000
`define FCPS_ID_DEV_WORD 19'h00001
`define FCPS_ID_DEV_BYTE 19'h00002
`define FCPS_PROT_WORD 19'h00002
`define FCPS_PROT_BYTE 19'h00004
`define FCPS_SETUP_CYC 4'h3
`define FCPS_STROBE_CYC 4'h8
`define FCPS_HOLD_CYC 4'h3
`endif

/* design/fcps_pkg.sv */
// types for the flash command and poll host controller
package fcps_pkg;
	typedef enum logic [3:0] {
		FCPS_OP_READ = 4'h0,
		FCPS_OP_RESET = 4'h1,
		FCPS_OP_AUTOSEL = 4'h2,
		FCPS_OP_PROGRAM = 4'h3,
		FCPS_OP_BYP_ENTER = 4'h4,
		FCPS_OP_BYP_PROGRAM = 4'h5,
		FCPS_OP_BYP_EXIT = 4'h6,
		FCPS_OP_CHIP_ERASE = 4'h7,
		FCPS_OP_SECTOR_ERASE = 4'h8,
		FCPS_OP_SUSPEND = 4'h9,
		FCPS_OP_RESUME = 4'hA
	} fcps_op_t;
	typedef struct packed {
		fcps_op_t op;
		logic [18:0] addr;
		logic [15:0] data;
		logic poll;
	} fcps_req_t;
	typedef struct packed {
		logic [15:0] rdata;
		logic done;
		logic fail;
	} fcps_rsp_t;
	typedef struct packed {
		logic [18:0] addr;
		logic [15:0] data;
	} fcps_cycle_t;
endpackage : fcps_pkg

/* design/fcps_host.sv */
// host controller issuing command sequences to a parallel nor flash
// How it works
// - every sequence cycle is a write, except array or autoselect reads
// - upper data byte driven zero except in program data cycles; high address bits only for bank/sector
// - plain array read needs no unlock or command cycle
// - single F0 write returns bank to array read
// - program: AA, 55, A0 at unlock address, then data to program_addr
// - bypass entry AA, 55, 20; bypass program A0 then data
// - bypass exit: 90 to bank address, then 00
// - erase: AA 55 80 AA 55 then 10 chip or 30 to sector
// - autoselect: AA 55 90 to bank unlock address, then bank read
// - suspend: one B0 write to bank address
// - resume: one 30 write to suspended bank address
// - after poll_bit matches, one more read gives valid data
// - on timeout flag, poll once more before declaring failure
// - polling uses program address or an erasing sector address
`timescale 1ns/1ps
`include "fcps_cfg.svh"
module fcps_host #(
	parameter int ADDR_W = `FCPS_ADDR_W,
	parameter int DATA_W = `FCPS_DATA_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic byte_mode,
	input wire logic req_valid,
	output logic req_ready,
	input wire fcps_pkg::fcps_req_t req,
	output fcps_pkg::fcps_rsp_t rsp,
	output logic [ADDR_W-1:0] flash_addr,
	input wire logic [DATA_W-1:0] flash_dq_in,
	output logic [DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe,
	output logic flash_chip_select_n,
	output logic flash_write_strobe_n,
	output logic flash_output_enable_n,
	input wire logic ready_busy_n
);
	import fcps_pkg::*;

	typedef enum logic [2:0] {
		FCPS_IDLE = 3'b000,
		FCPS_SETUP = 3'b001,
		FCPS_STROBE = 3'b011,
		FCPS_HOLD = 3'b010,
		FCPS_NEXT = 3'b110,
		FCPS_DONE = 3'b100
	} fcps_state_t;

	fcps_state_t state_r, state_nxt;
	fcps_req_t req_r;
	logic [3:0] cnt_r;
	logic [2:0] step_r;
	logic rd_r;
	logic [1:0] poll_phase_r;
	logic to_seen_r;
	fcps_cycle_t cyc;
	logic [2:0] n_cyc;
	logic [2:0] n_wr;
	logic [ADDR_W-1:0] ul1, ul2, bank_ul1, bank_base;
	logic [7:0] cmd;
	logic last_step, is_read, cnt_end, poll_done;
	logic [15:0] rdata_r;
	logic done_r, fail_r;

	// unlock addresses per bus width
	assign ul1 = byte_mode ? `FCPS_UL1_BYTE : `FCPS_UL1_WORD;
	assign ul2 = byte_mode ? `FCPS_UL2_BYTE : `FCPS_UL2_WORD;
	// bank bits kept, other high bits zero
	assign bank_base = {req_r.addr[ADDR_W-1:`FCPS_BANK_LSB],
		{`FCPS_BANK_LSB{1'b0}}};
	assign bank_ul1 = bank_base | ul1;

	// write count and total cycles per operation
	always_comb begin
		n_wr = 3'd1;
		case (req_r.op)
		FCPS_OP_READ: n_wr = 3'd0;
		FCPS_OP_RESET: n_wr = 3'd1;
		FCPS_OP_AUTOSEL: n_wr = 3'd3;
		FCPS_OP_PROGRAM: n_wr = 3'd4;
		FCPS_OP_BYP_ENTER: n_wr = 3'd3;
		FCPS_OP_BYP_PROGRAM: n_wr = 3'd2;
		FCPS_OP_BYP_EXIT: n_wr = 3'd2;
		FCPS_OP_CHIP_ERASE: n_wr = 3'd6;
		FCPS_OP_SECTOR_ERASE: n_wr = 3'd6;
		default: n_wr = 3'd1;
		endcase
	end
	// autoselect and read finish with one read cycle
	assign n_cyc = (req_r.op == FCPS_OP_READ || req_r.op == FCPS_OP_AUTOSEL)
		? n_wr + 3'd1 : n_wr;

	// address and command of the current write step
	always_comb begin
		cyc.addr = ul1;
		cmd = `FCPS_D_AA;
		case (req_r.op)
		FCPS_OP_RESET: begin
			cyc.addr = '0;
			cmd = `FCPS_D_F0;
		end
		FCPS_OP_BYP_PROGRAM: begin
			cyc.addr = '0;
			cmd = `FCPS_D_A0;
		end
		FCPS_OP_BYP_EXIT: begin
			cyc.addr = (step_r == 3'd0) ? bank_base : '0;
			cmd = (step_r == 3'd0) ? `FCPS_D_90 : `FCPS_D_00;
		end
		FCPS_OP_SUSPEND: begin
			cyc.addr = bank_base;
			cmd = `FCPS_D_B0;
		end
		FCPS_OP_RESUME: begin
			cyc.addr = bank_base;
			cmd = `FCPS_D_30;
		end
		default: begin
			case (step_r)
			3'd0, 3'd3: begin
				cyc.addr = ul1;
				cmd = `FCPS_D_AA;
			end
			3'd1, 3'd4: begin
				cyc.addr = ul2;
				cmd = `FCPS_D_55;
			end
			3'd2: begin
				cyc.addr = (req_r.op == FCPS_OP_AUTOSEL) ? bank_ul1 : ul1;
				cmd = (req_r.op == FCPS_OP_AUTOSEL) ? `FCPS_D_90 :
					(req_r.op == FCPS_OP_PROGRAM) ? `FCPS_D_A0 :
					(req_r.op == FCPS_OP_BYP_ENTER) ? `FCPS_D_20 :
					`FCPS_D_80;
			end
			default: begin
				cyc.addr = (req_r.op == FCPS_OP_SECTOR_ERASE) ?
					req_r.addr : ul1;
				cmd = (req_r.op == FCPS_OP_SECTOR_ERASE) ? `FCPS_D_30 :
					`FCPS_D_10;
			end
			endcase
		end
		endcase
		cyc.data = {8'h00, cmd};
		// final data cycle of a program carries full data
		if ((req_r.op == FCPS_OP_PROGRAM && step_r == 3'd3) ||
			(req_r.op == FCPS_OP_BYP_PROGRAM && step_r == 3'd1)) begin
			cyc.addr = req_r.addr;
			cyc.data = req_r.data;
		end
	end

	assign is_read = rd_r || (step_r >= n_wr);
	assign last_step = (step_r + 3'd1 >= n_cyc);
	assign cnt_end = (state_r == FCPS_SETUP && cnt_r == `FCPS_SETUP_CYC) ||
		(state_r == FCPS_STROBE && cnt_r == `FCPS_STROBE_CYC) ||
		(state_r == FCPS_HOLD && cnt_r == `FCPS_HOLD_CYC);
	// program done when poll bit matches written bit 7, erase when 1
	assign poll_done = (req_r.op == FCPS_OP_PROGRAM ||
		req_r.op == FCPS_OP_BYP_PROGRAM) ?
		(flash_dq_in[`FCPS_POLL_BIT] == req_r.data[`FCPS_POLL_BIT]) :
		flash_dq_in[`FCPS_POLL_BIT];
	assign req_ready = (state_r == FCPS_IDLE);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
		FCPS_IDLE: if (req_valid) state_nxt = FCPS_SETUP;
		FCPS_SETUP: if (cnt_end) state_nxt = FCPS_STROBE;
		FCPS_STROBE: if (cnt_end) state_nxt = FCPS_HOLD;
		FCPS_HOLD: if (cnt_end) state_nxt = FCPS_NEXT;
		FCPS_NEXT: state_nxt = FCPS_SETUP;
		FCPS_DONE: state_nxt = FCPS_IDLE;
		default: state_nxt = FCPS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) state_r <= FCPS_IDLE;
		else if (state_r == FCPS_NEXT && last_step && (!req_r.poll ||
			poll_phase_r == 2'd3 || (rd_r && fail_r)))
			state_r <= FCPS_DONE;
		else state_r <= state_nxt;
	end

	always_ff @(posedge clk) begin
		if (rst || state_r == FCPS_IDLE || state_r == FCPS_NEXT) cnt_r <= 4'h0;
		else if (cnt_end) cnt_r <= 4'h0;
		else cnt_r <= cnt_r + 4'h1;
	end

	// step, polling phases and capture of returned data
	always_ff @(posedge clk) begin
		if (rst) begin
			req_r <= '0;
			step_r <= 3'd0;
			rd_r <= 1'b0;
			poll_phase_r <= 2'd0;
			to_seen_r <= 1'b0;
			rdata_r <= '0;
			done_r <= 1'b0;
			fail_r <= 1'b0;
		end else begin
			done_r <= (state_r == FCPS_DONE);
			if (state_r == FCPS_IDLE && req_valid) begin
				req_r <= req;
				step_r <= 3'd0;
				rd_r <= 1'b0;
				poll_phase_r <= 2'd0;
				to_seen_r <= 1'b0;
				fail_r <= 1'b0;
			// sample on the last output-enable cycle, before release
			end else if (state_r == FCPS_STROBE && cnt_end && is_read && !rd_r)
				rdata_r <= flash_dq_in;
			else if (state_r == FCPS_STROBE && cnt_end && rd_r) begin
				// polling reads at the request address
				if (poll_phase_r == 2'd1 && poll_done)
					poll_phase_r <= 2'd2;
				else if (poll_phase_r == 2'd2) poll_phase_r <= 2'd3;
				else if (to_seen_r) fail_r <= 1'b1;
				else if (flash_dq_in[`FCPS_TIMEOUT_BIT])
					to_seen_r <= 1'b1;
				rdata_r <= flash_dq_in;
			end else if (state_r == FCPS_NEXT && !last_step)
				step_r <= step_r + 3'd1;
			else if (state_r == FCPS_NEXT && req_r.poll && !rd_r) begin
				rd_r <= 1'b1;
				poll_phase_r <= 2'd1;
			end
		end
	end

	// polling address, final read address or sequence address
	always_ff @(posedge clk) begin
		if (rst) begin
			flash_addr <= '0;
			flash_dq_out <= '0;
			flash_dq_oe <= 1'b0;
		end else begin
			flash_addr <= is_read ? req_r.addr : cyc.addr;
			flash_dq_out <= cyc.data;
			flash_dq_oe <= !is_read && state_r != FCPS_IDLE &&
				state_r != FCPS_DONE;
		end
	end

	assign flash_chip_select_n = !(state_r == FCPS_SETUP ||
		state_r == FCPS_STROBE || state_r == FCPS_HOLD);
	assign flash_write_strobe_n = !(state_r == FCPS_STROBE && !is_read);
	assign flash_output_enable_n = !(state_r == FCPS_STROBE && is_read);
	assign rsp.rdata = rdata_r;
	assign rsp.done = done_r;
	assign rsp.fail = fail_r;
endmodule : fcps_host

/* tb/fcps_host_sva.sv */
// assertion checker for the flash host controller
`timescale 1ns/1ps
module fcps_host_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic req_ready,
	input wire fcps_pkg::fcps_rsp_t rsp,
	input wire logic [18:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_dq_oe,
	input wire logic flash_chip_select_n,
	input wire logic flash_write_strobe_n,
	input wire logic flash_output_enable_n
);
	import fcps_pkg::*;
	wire cs_n = flash_chip_select_n;
	wire we_n = flash_write_strobe_n;
	wire oe_n = flash_output_enable_n;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	AST_WE_CS: assert property (!we_n |-> !cs_n && flash_dq_oe)
		else $error("write strobe unselected");
	AST_WE_LEN: assert property ($fell(we_n) |=> !we_n [*8] ##1 we_n)
		else $error("write strobe length");
	AST_WE_SETUP: assert property ($fell(we_n) |-> !$past(cs_n))
		else $error("no select setup");
	AST_ADDR_HELD: assert property (!we_n |-> $stable(flash_addr))
		else $error("address moved");
	AST_DATA_HELD: assert property ($rose(we_n) |->
		$stable(flash_dq_out) && flash_dq_oe) else $error("data not held");
	AST_OE_READ: assert property (!oe_n |-> !cs_n && we_n && !flash_dq_oe)
		else $error("bad read cycle");
	AST_IDLE: assert property (req_ready |-> cs_n && we_n && oe_n)
		else $error("bus busy while idle");
	AST_DONE: assert property (rsp.done |-> req_ready ##1 !rsp.done)
		else $error("bad done pulse");
	cover property ($fell(we_n));
	cover property ($fell(oe_n));
	cover property (rsp.done);
endmodule : fcps_host_sva

/* tb/fcps_flash_model.sv */
// behavioural flash device facing the host controller
`timescale 1ns/1ps
module fcps_flash_model #(
	parameter logic [15:0] MAKER = 16'h00C3, // arbitrary
	parameter logic [15:0] DEV = 16'h5A5A, // arbitrary
	parameter logic [6:0] PROT_SECT = 7'h7F
) (
	input wire logic byte_mode,
	input wire logic [18:0] flash_addr,
	output logic [15:0] flash_dq_in,
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_chip_select_n,
	input wire logic flash_write_strobe_n,
	input wire logic flash_output_enable_n,
	output logic ready_busy_n
);
	logic [15:0] mem [int];
	logic [15:0] pd = '0;
	logic [15:0] rd;
	logic [7:0] d;
	logic [7:0] aofs;
	logic [6:0] esec = '0;
	logic [2:0] abank = '0;
	logic asel = 0, byp = 0, susp = 0, ers = 0, tog = 0;
	int st = 0;
	int nx;
	int busy = 0;
	wire sec = st == 1 || st == 5;
	wire [11:0] ul = sec ? (byte_mode ? 12'h555 : 12'h2AA)
		: (byte_mode ? 12'hAAA : 12'h555);
	wire ok = flash_addr[11:0] == ul;
	wire prot = flash_addr[18:12] == PROT_SECT;
	wire off = flash_chip_select_n || flash_output_enable_n;
	assign ready_busy_n = !(busy != 0 && !susp);
	assign flash_dq_in = off ? ~rd : rd;
	always @* begin
		aofs = byte_mode ? flash_addr[7:0] >> 1 : flash_addr[7:0];
		if (asel && flash_addr[18:16] == abank) begin
			rd = aofs == 8'h00 ? MAKER : aofs == 8'h01 ? DEV
				: {15'h0, prot};
		end else if (susp && flash_addr[18:12] == esec)
			rd = 16'h0080;
		else if (busy != 0 && !susp)
			rd = {8'h00, !ers && !pd[7], tog, 6'h00};
		else
			rd = mem.exists(flash_addr) ? mem[flash_addr] : 16'hFFFF;
	end
	always @(posedge flash_write_strobe_n) if (!flash_chip_select_n) begin
		d = flash_dq_out[7:0];
		nx = 0;
		if (d == 8'hF0) asel = 0;
		else if (st == 3) begin
			if (!prot) mem[flash_addr] = flash_dq_out;
			pd = flash_dq_out;
			busy = prot ? 1 : 3;
			ers = 0;
		end else if (st == 7) byp = d != 8'h00;
		else if (byp) nx = d == 8'hA0 ? 3 : d == 8'h90 ? 7 : 0;
		else if (st == 0 && d == 8'hB0) susp = busy != 0 && ers;
		else if (st == 0 && d == 8'h30) susp = 0;
		else if (ok && (d == 8'hAA && st % 4 == 0 || d == 8'h55 && sec)) nx = st + 1;
		else if (st == 2 && ok) begin
			nx = d == 8'hA0 ? 3 : d == 8'h80 ? 4 : 0;
			byp = d == 8'h20;
			asel = d == 8'h90;
			abank = flash_addr[18:16];
		end else if (st == 6 && (d == 8'h10 || d == 8'h30)) begin
			esec = flash_addr[18:12];
			if (d == 8'h10) mem.delete();
			else if (!prot) begin
				for (int k = 0; k < 4096; k++)
					if (mem.exists({esec, k[11:0]}))
						mem.delete({esec, k[11:0]});
			end
			ers = 1;
			busy = 3;
		end
		st = nx;
	end
	always @(posedge flash_output_enable_n)
		if (!flash_chip_select_n && busy != 0 && !susp) begin
			busy--;
			tog = ~tog;
		end
endmodule : fcps_flash_model

/* tb/tb_top.sv */
// testbench for the flash host controller
`timescale 1ns/1ps
module tb_top;
	import fcps_pkg::*;
	localparam logic [15:0] MAKER = 16'h00C3; // arbitrary
	localparam logic [15:0] DEV = 16'h5A5A; // arbitrary
	logic clk = 0;
	logic rst = 1;
	logic byte_mode = 0;
	logic req_valid = 0;
	logic req_ready, flash_dq_oe, ready_busy_n;
	fcps_req_t req = '0;
	fcps_rsp_t rsp;
	logic [18:0] flash_addr;
	logic [15:0] flash_dq_in, flash_dq_out;
	logic flash_chip_select_n, flash_write_strobe_n, flash_output_enable_n;
	fcps_op_t er [2] = '{FCPS_OP_CHIP_ERASE, FCPS_OP_SECTOR_ERASE};
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	always #2.5 clk = ~clk;
	fcps_host i_fcps_host (.clk, .rst, .byte_mode, .req_valid, .req_ready,
		.req, .rsp, .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe,
		.flash_chip_select_n, .flash_write_strobe_n, .flash_output_enable_n,
		.ready_busy_n);
	fcps_flash_model #(.MAKER(MAKER), .DEV(DEV)) i_fcps_flash_model (
		.byte_mode, .flash_addr, .flash_dq_in, .flash_dq_out,
		.flash_chip_select_n, .flash_write_strobe_n, .flash_output_enable_n,
		.ready_busy_n);
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict
	task automatic run(input fcps_op_t op, input logic [18:0] a,
		input logic [15:0] d, input logic p);
		int n;
		n = 0;
		@(posedge clk);
		req_valid <= 1'h1;
		req <= '{op, a, d, p};
		@(posedge clk);
		req_valid <= 1'h0;
		@(negedge clk);
		while (rsp.done !== 1'h1 && n < 4000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 4000) fails++;
	endtask : run
	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
		$display("test %s done", what);
	endtask : chk
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		run(FCPS_OP_PROGRAM, 19'h00100, 16'h1234, 1'h1);
		chk("program poll", rsp.rdata, 16'h1234);
		chk("fail flag", {15'h0, rsp.fail}, 16'h0000);
		run(FCPS_OP_READ, 19'h00100, 16'h0000, 1'h0);
		chk("array read", rsp.rdata, 16'h1234);
		run(FCPS_OP_AUTOSEL, 19'h10000, 16'h0000, 1'h0);
		chk("maker code", rsp.rdata, MAKER);
		run(FCPS_OP_READ, 19'h00100, 16'h0000, 1'h0);
		chk("other bank", rsp.rdata, 16'h1234);
		run(FCPS_OP_AUTOSEL, 19'h10001, 16'h0000, 1'h0);
		chk("device code", rsp.rdata, DEV);
		run(FCPS_OP_AUTOSEL, 19'h10002, 16'h0000, 1'h0);
		chk("unprotected", rsp.rdata, 16'h0000);
		run(FCPS_OP_AUTOSEL, 19'h7F002, 16'h0000, 1'h0);
		chk("protected", rsp.rdata, 16'h0001);
		run(FCPS_OP_RESET, 19'h00000, 16'h0000, 1'h0);
		run(FCPS_OP_READ, 19'h00100, 16'h0000, 1'h0);
		chk("reset read", rsp.rdata, 16'h1234);
		run(FCPS_OP_BYP_ENTER, 19'h00000, 16'h0000, 1'h0);
		run(FCPS_OP_BYP_PROGRAM, 19'h00200, 16'h00AB, 1'h1);
		run(FCPS_OP_BYP_EXIT, 19'h00000, 16'h0000, 1'h0);
		run(FCPS_OP_READ, 19'h00200, 16'h0000, 1'h0);
		chk("bypass", rsp.rdata, 16'h00AB);
		@(posedge clk);
		byte_mode <= 1'h1;
		run(FCPS_OP_PROGRAM, 19'h00300, 16'h8001, 1'h1);
		chk("byte unlock", rsp.rdata, 16'h8001);
		@(posedge clk);
		byte_mode <= 1'h0;
		foreach (er[i]) begin
			run(FCPS_OP_PROGRAM, 19'h00100, 16'h1234, 1'h1);
			run(er[i], 19'h00000, 16'h0000, 1'h1);
			run(FCPS_OP_READ, 19'h00100, 16'h0000, 1'h0);
			chk("erase", rsp.rdata, 16'hFFFF);
		end
		run(FCPS_OP_PROGRAM, 19'h7F000, 16'h0080, 1'h1);
		chk("protected program", rsp.rdata, 16'hFFFF);
		run(FCPS_OP_PROGRAM, 19'h01000, 16'h0042, 1'h1);
		run(FCPS_OP_SECTOR_ERASE, 19'h7F000, 16'h0000, 1'h1);
		run(FCPS_OP_READ, 19'h01000, 16'h0000, 1'h0);
		chk("protected erase", rsp.rdata, 16'h0042);
		run(FCPS_OP_SECTOR_ERASE, 19'h00000, 16'h0000, 1'h0);
		run(FCPS_OP_SUSPEND, 19'h00000, 16'h0000, 1'h0);
		run(FCPS_OP_READ, 19'h00000, 16'h0000, 1'h0);
		chk("suspend", rsp.rdata & 16'h0080, 16'h0080);
		run(FCPS_OP_READ, 19'h01000, 16'h0000, 1'h0);
		chk("suspend other sector", rsp.rdata, 16'h0042);
		run(FCPS_OP_RESUME, 19'h00000, 16'h0000, 1'h0);
		run(FCPS_OP_READ, 19'h00000, 16'h0000, 1'h0);
		chk("resume", rsp.rdata & 16'h0080, 16'h0000);
		give_verdict();
	end
endmodule : tb_top
bind fcps_host fcps_host_sva i_fcps_host_sva (.clk, .rst, .req_ready, .rsp,
	.flash_addr, .flash_dq_out, .flash_dq_oe, .flash_chip_select_n,
	.flash_write_strobe_n, .flash_output_enable_n);
